//--- pdl_pkg.sv
// Shared constants and types for the delimiter, link and negotiation block
package pdl_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int US_NS         = 1000;
	localparam int MS_NS         = 1000000;
	localparam int HOLD_MS       = 1200;
	localparam int JAB_US        = 20000;
	localparam int MS_CYC_DEF    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int JAB_CYC_DEF   = (JAB_US * US_NS) / CLK_PERIOD_NS;
	localparam int HOLD_W        = 11;
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_MS - 1);

	// Register map
	localparam int AW = 3;
	localparam int DW = 16;
	localparam logic [AW-1:0] ADR_MAC_CTRL = 3'h0;
	localparam logic [AW-1:0] ADR_PHY_CTRL = 3'h1;
	localparam logic [AW-1:0] ADR_ADV      = 3'h2;
	localparam logic [AW-1:0] ADR_PARTNER  = 3'h3;
	localparam logic [AW-1:0] ADR_STATUS   = 3'h4;

	// Control fields
	localparam int MAC_W          = 3;
	localparam int PHY_W          = 6;
	localparam int CB_NEG_EN      = 0;
	localparam int CB_SPEED       = 1;
	localparam int CB_DUPLEX      = 2;
	localparam int CB_RESTART     = 3;
	localparam int CB_LINK_DIS    = 4;
	localparam int CB_JAB_DIS     = 5;
	localparam logic [MAC_W-1:0] MAC_CTRL_RST = 3'h0;
	localparam logic [PHY_W-1:0] PHY_CTRL_RST = 6'h01;

	// Status fields
	localparam int SB_NEG_DONE = 0;
	localparam int SB_LINK     = 1;
	localparam int SB_SPD_DET  = 2;
	localparam int SB_DPX_DET  = 3;
	localparam int SB_BAD_SSD  = 4;
	localparam int SB_BAD_ESD  = 5;
	localparam int SB_JABBER   = 6;

	// Advertisement ability bits
	localparam int AB_100FD = 8;
	localparam int AB_100HD = 7;
	localparam int AB_10FD  = 6;
	localparam int AB_10HD  = 5;
	localparam logic [DW-1:0] ADV_RST = 16'h01E1;

	// Code groups
	localparam int SYM_W = 5;
	localparam logic [SYM_W-1:0] SYM_I = 5'h1F;
	localparam logic [SYM_W-1:0] SYM_J = 5'h18;
	localparam logic [SYM_W-1:0] SYM_K = 5'h11;
	localparam logic [SYM_W-1:0] SYM_T = 5'h0D;
	localparam logic [SYM_W-1:0] SYM_R = 5'h07;
	localparam logic [2:0] SYM_LAST_BIT = 3'h4;
	localparam logic [3:0] NIB_PREAMBLE = 4'h5;

	typedef enum logic [1:0] {
		PDL_AN_OFF  = 2'b00,
		PDL_AN_HOLD = 2'b01,
		PDL_AN_DET  = 2'b10,
		PDL_AN_DONE = 2'b11
	} pdl_an_t;

	typedef enum logic [1:0] {
		PDL_RX_IDLE = 2'b00,
		PDL_RX_RECV = 2'b01,
		PDL_RX_FCAR = 2'b10
	} pdl_rx_t;

	typedef enum logic [1:0] {
		PDL_TX_IDLE = 2'b00,
		PDL_TX_K    = 2'b01,
		PDL_TX_DATA = 2'b10,
		PDL_TX_R    = 2'b11
	} pdl_tx_t;
endpackage

//--- pdl_tick_div.sv
// Divider producing a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module pdl_tick_div #(
	parameter int DIV = 100000
) (
	input  wire logic core_clk,   // System clock
	input  wire logic rst,        // Asynchronous reset, active high
	output logic      tick        // One-cycle pulse every DIV cycles
);
	localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (cnt_r == LAST) begin
			cnt_r <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule

//--- pdl_core.sv
// Delimiter insertion and detection, link integrity, negotiation and jabber
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module pdl_core
	import pdl_pkg::*;
#(
	parameter int MS_CYC  = pdl_pkg::MS_CYC_DEF,
	parameter int JAB_CYC = pdl_pkg::JAB_CYC_DEF
) (
	input  wire logic                   core_clk,           // System clock
	input  wire logic                   rst,                // Asynchronous reset
	input  wire logic [pdl_pkg::AW-1:0] reg_addr,           // Register address
	input  wire logic [pdl_pkg::DW-1:0] reg_wdata,          // Register write data
	input  wire logic                   reg_wr,             // Write strobe
	input  wire logic                   reg_rd,             // Read strobe
	output logic      [pdl_pkg::DW-1:0] reg_rdata,          // Read data, cycle after strobe
	input  wire logic                   transmit_enable,    // MAC transmit enable
	input  wire logic [3:0]             tx_nibble,          // MAC transmit nibble
	output logic      [4:0]             tx_code,            // Encoded code group out
	output logic                        start_of_idle_pulse,// 10 Mbps end-of-frame pulse
	output logic                        link_pulse_enable,  // Link pulse generator allowed
	output logic                        tx_line_idle,       // Line outputs forced idle
	output logic                        collision,          // Collision to MAC
	input  wire logic                   rx_bit,             // Descrambled code bit
	input  wire logic                   squelch_valid,      // Squelch reports valid input
	input  wire logic                   descr_locked,       // Descrambler synchronised
	input  wire logic                   soi_detect,         // Missing transitions seen
	input  wire logic                   nlp_link_ok,        // 10 Mbps link pulses good
	input  wire logic                   flp_seen,           // Fast link pulse bursts seen
	input  wire logic                   partner_word_valid, // Partner word received
	input  wire logic [15:0]            partner_word,       // Partner capability word
	output logic      [3:0]             rx_nibble,          // Receive nibble to MAC
	output logic                        rx_dv,              // Receive data valid
	output logic                        rx_er,              // Receive error
	output logic                        false_carrier,      // False carrier pulse
	output logic                        crs,                // Carrier sense
	output logic                        adv_send,           // Send advertisement now
	output logic      [15:0]            adv_word,           // Advertisement word to send
	output logic                        link_pass,          // Link pass state
	output logic                        speed_100,          // Applied speed is 100 Mbps
	output logic                        full_duplex         // Applied duplex is full
);
	import pdl_pkg::*;

	function automatic logic [4:0] enc4(input logic [3:0] n);
		case (n)
			4'h0: enc4 = 5'h1E;
			4'h1: enc4 = 5'h09;
			4'h2: enc4 = 5'h14;
			4'h3: enc4 = 5'h15;
			4'h4: enc4 = 5'h0A;
			4'h5: enc4 = 5'h0B;
			4'h6: enc4 = 5'h0E;
			4'h7: enc4 = 5'h0F;
			4'h8: enc4 = 5'h12;
			4'h9: enc4 = 5'h13;
			4'hA: enc4 = 5'h16;
			4'hB: enc4 = 5'h17;
			4'hC: enc4 = 5'h1A;
			4'hD: enc4 = 5'h1B;
			4'hE: enc4 = 5'h1C;
			default: enc4 = 5'h1D;
		endcase
	endfunction

	// Returns {valid, nibble}
	function automatic logic [4:0] dec5(input logic [4:0] c);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (enc4(4'(i)) == c) begin
				r = {1'b1, 4'(i)};
			end
		end
		dec5 = r;
	endfunction

	// True when two zeros exist that are not neighbours
	function automatic logic split_zeros(input logic [9:0] w);
		logic f;
		f = 1'b0;
		for (int i = 0; i < 10; i++) begin
			for (int j = i + 2; j < 10; j++) begin
				if (!w[i] && !w[j]) begin
					f = 1'b1;
				end
			end
		end
		split_zeros = f;
	endfunction

	localparam int JAB_W = $clog2(JAB_CYC + 1);
	localparam logic [JAB_W-1:0] JAB_LAST = JAB_W'(JAB_CYC - 1);

	logic [MAC_W-1:0]  mac_ctrl_r;
	logic [PHY_W-1:0]  phy_ctrl_r;
	logic [DW-1:0]     adv_r;
	logic [DW-1:0]     partner_r;
	logic              restart_r;
	logic              bad_ssd_r;
	logic              bad_esd_r;
	logic              jab_st_r;
	logic              ssd_evt_r;
	logic              esd_evt_r;
	logic              ms_tick;
	pdl_an_t           an_state_r;
	logic [HOLD_W-1:0] hold_cnt_r;
	logic              an_en_d_r;
	logic              neg_spd_r;
	logic              neg_dpx_r;
	pdl_tx_t           tx_state_r;
	pdl_tx_t           tx_state_nxt;
	logic [SYM_W-1:0]  tx_code_nxt;
	logic              te_d_r;
	logic [JAB_W-1:0]  jab_cnt_r;
	logic              jabber_r;
	logic [9:0]        win_r;
	logic [2:0]        bit_cnt_r;
	logic              kpend_r;
	pdl_rx_t           rx_state_r;
	logic              rx10_act_r;
	logic              sq_d_r;
	logic [4:0]        dec_hi;

	wire mac_en   = mac_ctrl_r[CB_NEG_EN];
	wire phy_en   = phy_ctrl_r[CB_NEG_EN];
	wire link_dis = phy_ctrl_r[CB_LINK_DIS];
	wire an_en    = mac_en & phy_en;
	wire hold     = an_en & (an_state_r == PDL_AN_HOLD);
	wire suppress = hold | jabber_r;
	wire link100  = squelch_valid & descr_locked;
	wire st_rd    = reg_rd && (reg_addr == ADR_STATUS);
	wire [DW-1:0] common = adv_r & partner_word;

	pdl_tick_div #(
		.DIV(MS_CYC)
	) u_ms_tick (
		.core_clk(core_clk),
		.rst     (rst),
		.tick    (ms_tick)
	);

	// Register writes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mac_ctrl_r <= MAC_CTRL_RST;
			phy_ctrl_r <= PHY_CTRL_RST;
			adv_r      <= ADV_RST;
			restart_r  <= 1'b0;
		end else begin
			restart_r <= reg_wr && (reg_addr == ADR_PHY_CTRL) && reg_wdata[CB_RESTART];
			if (reg_wr) begin
				if (reg_addr == ADR_MAC_CTRL) begin
					mac_ctrl_r <= reg_wdata[MAC_W-1:0];
				end else if (reg_addr == ADR_PHY_CTRL) begin
					phy_ctrl_r <= reg_wdata[PHY_W-1:0] & ~(6'h01 << CB_RESTART);
				end else if (reg_addr == ADR_ADV) begin
					adv_r <= reg_wdata;
				end
			end
		end
	end

	// Register reads, data valid only in the cycle after the strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else if (reg_addr == ADR_MAC_CTRL) begin
			reg_rdata <= DW'(mac_ctrl_r);
		end else if (reg_addr == ADR_PHY_CTRL) begin
			reg_rdata <= DW'(phy_ctrl_r);
		end else if (reg_addr == ADR_ADV) begin
			reg_rdata <= adv_r;
		end else if (reg_addr == ADR_PARTNER) begin
			reg_rdata <= partner_r;
		end else if (reg_addr == ADR_STATUS) begin
			reg_rdata <= '0;
			reg_rdata[SB_NEG_DONE] <= an_en & (an_state_r == PDL_AN_DONE);
			reg_rdata[SB_LINK]     <= link_pass;
			reg_rdata[SB_SPD_DET]  <= neg_spd_r;
			reg_rdata[SB_DPX_DET]  <= neg_dpx_r;
			reg_rdata[SB_BAD_SSD]  <= bad_ssd_r;
			reg_rdata[SB_BAD_ESD]  <= bad_esd_r;
			reg_rdata[SB_JABBER]   <= jab_st_r;
		end else begin
			reg_rdata <= '0;
		end
	end

	// Sticky status, cleared by reading; a new event wins over the clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bad_ssd_r <= 1'b0;
			bad_esd_r <= 1'b0;
			jab_st_r  <= 1'b0;
		end else begin
			bad_ssd_r <= ssd_evt_r | (bad_ssd_r & ~st_rd);
			bad_esd_r <= esd_evt_r | (bad_esd_r & ~st_rd);
			jab_st_r  <= jabber_r | (jab_st_r & ~st_rd);
		end
	end

	// Negotiation sequencing
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			an_state_r <= PDL_AN_OFF;
			hold_cnt_r <= '0;
			an_en_d_r  <= 1'b0;
			neg_spd_r  <= 1'b0;
			neg_dpx_r  <= 1'b0;
			partner_r  <= '0;
			adv_send   <= 1'b0;
			adv_word   <= ADV_RST;
		end else begin
			an_en_d_r <= an_en;
			adv_word  <= adv_r;
			adv_send  <= an_en && (an_state_r == PDL_AN_DET) && flp_seen;
			if (!an_en) begin
				an_state_r <= PDL_AN_OFF;
			end else if (!an_en_d_r || restart_r) begin
				an_state_r <= PDL_AN_HOLD;
				hold_cnt_r <= '0;
			end else begin
				case (an_state_r)
					PDL_AN_HOLD: begin
						if (ms_tick) begin
							if (hold_cnt_r == HOLD_LAST) begin
								an_state_r <= PDL_AN_DET;
							end else begin
								hold_cnt_r <= hold_cnt_r + 1'b1;
							end
						end
					end
					PDL_AN_DET: begin
						if (flp_seen) begin
							if (partner_word_valid) begin
								partner_r  <= partner_word;
								an_state_r <= PDL_AN_DONE;
								neg_spd_r  <= common[AB_100FD] | common[AB_100HD];
								neg_dpx_r  <= common[AB_100FD] |
									(~common[AB_100HD] & common[AB_10FD]);
							end
						end else if (link100) begin
							an_state_r <= PDL_AN_DONE;
							neg_spd_r  <= 1'b1;
							neg_dpx_r  <= 1'b0;
						end else if (nlp_link_ok) begin
							an_state_r <= PDL_AN_DONE;
							neg_spd_r  <= 1'b0;
							neg_dpx_r  <= 1'b0;
						end
					end
					PDL_AN_DONE: begin
						// Link integrity of the chosen speed; failure renegotiates
						if (!(neg_spd_r ? link100 : nlp_link_ok)) begin
							an_state_r <= PDL_AN_HOLD;
							hold_cnt_r <= '0;
						end
					end
					default: begin
						an_state_r <= PDL_AN_HOLD;
						hold_cnt_r <= '0;
					end
				endcase
			end
		end
	end

	// Applied speed, duplex and link state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			speed_100         <= 1'b0;
			full_duplex       <= 1'b0;
			link_pass         <= 1'b0;
			link_pulse_enable <= 1'b0;
		end else begin
			if (link_dis || (mac_en && !phy_en)) begin
				speed_100   <= phy_ctrl_r[CB_SPEED];
				full_duplex <= phy_ctrl_r[CB_DUPLEX];
			end else if (!mac_en) begin
				speed_100   <= mac_ctrl_r[CB_SPEED];
				full_duplex <= mac_ctrl_r[CB_DUPLEX];
			end else begin
				speed_100   <= neg_spd_r;
				full_duplex <= neg_dpx_r;
			end
			if (link_dis) begin
				link_pass <= 1'b1;
			end else if (an_en && (an_state_r != PDL_AN_DONE)) begin
				link_pass <= 1'b0;
			end else begin
				link_pass <= speed_100 ? link100 : nlp_link_ok;
			end
			link_pulse_enable <= link_dis | ~hold;
		end
	end

	// Transmit delimiter insertion
	always_comb begin
		tx_state_nxt = tx_state_r;
		tx_code_nxt  = SYM_I;
		case (tx_state_r)
			PDL_TX_IDLE: begin
				if (transmit_enable) begin
					tx_code_nxt  = SYM_J;
					tx_state_nxt = PDL_TX_K;
				end
			end
			PDL_TX_K: begin
				tx_code_nxt  = SYM_K;
				tx_state_nxt = PDL_TX_DATA;
			end
			PDL_TX_DATA: begin
				if (transmit_enable) begin
					tx_code_nxt = enc4(tx_nibble);
				end else begin
					tx_code_nxt  = SYM_T;
					tx_state_nxt = PDL_TX_R;
				end
			end
			default: begin
				tx_code_nxt  = SYM_R;
				tx_state_nxt = PDL_TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_state_r          <= PDL_TX_IDLE;
			tx_code             <= SYM_I;
			te_d_r              <= 1'b0;
			start_of_idle_pulse <= 1'b0;
			tx_line_idle        <= 1'b1;
		end else begin
			te_d_r       <= transmit_enable;
			tx_line_idle <= suppress;
			tx_state_r   <= speed_100 ? tx_state_nxt : PDL_TX_IDLE;
			tx_code      <= (speed_100 && !suppress) ? tx_code_nxt : SYM_I;
			start_of_idle_pulse <= !speed_100 && te_d_r && !transmit_enable && !suppress;
		end
	end

	// Jabber watch on 10 Mbps transmissions
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			jab_cnt_r <= '0;
			jabber_r  <= 1'b0;
			collision <= 1'b0;
		end else begin
			collision <= jabber_r;
			if (speed_100 || phy_ctrl_r[CB_JAB_DIS] || !transmit_enable) begin
				jab_cnt_r <= '0;
				jabber_r  <= 1'b0;
			end else if (jab_cnt_r == JAB_LAST) begin
				jabber_r <= 1'b1;
			end else begin
				jab_cnt_r <= jab_cnt_r + 1'b1;
			end
		end
	end

	// Receive window: newest bit in bit 0, older group in the upper half
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			win_r <= {SYM_I, SYM_I};
		end else begin
			win_r <= {win_r[8:0], rx_bit};
		end
	end

	assign dec_hi = dec5(win_r[9:5]);

	// 100 Mbps delimiter detection
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_state_r    <= PDL_RX_IDLE;
			bit_cnt_r     <= '0;
			kpend_r       <= 1'b0;
			rx_nibble     <= '0;
			rx_dv         <= 1'b0;
			rx_er         <= 1'b0;
			false_carrier <= 1'b0;
			ssd_evt_r     <= 1'b0;
			esd_evt_r     <= 1'b0;
		end else begin
			false_carrier <= 1'b0;
			ssd_evt_r     <= 1'b0;
			esd_evt_r     <= 1'b0;
			if (!speed_100) begin
				rx_state_r <= PDL_RX_IDLE;
				rx_dv      <= 1'b0;
				rx_er      <= 1'b0;
			end else begin
				case (rx_state_r)
					PDL_RX_IDLE: begin
						rx_dv <= 1'b0;
						rx_er <= 1'b0;
						if (win_r == {SYM_J, SYM_K}) begin
							rx_state_r <= PDL_RX_RECV;
							bit_cnt_r  <= '0;
							kpend_r    <= 1'b1;
							rx_dv      <= 1'b1;
							rx_nibble  <= NIB_PREAMBLE;
						// Judge once the earliest zero is oldest: a J/K still arriving is spared
						end else if (win_r != {SYM_I, SYM_I} && split_zeros(win_r) &&
							!win_r[2*SYM_W-1]) begin
							rx_state_r    <= PDL_RX_FCAR;
							rx_er         <= 1'b1;
							false_carrier <= 1'b1;
							ssd_evt_r     <= 1'b1;
						end
					end
					PDL_RX_FCAR: begin
						rx_er <= 1'b0;
						if (win_r == {SYM_I, SYM_I}) begin
							rx_state_r <= PDL_RX_IDLE;
						end
					end
					PDL_RX_RECV: begin
						if (bit_cnt_r == SYM_LAST_BIT) begin
							bit_cnt_r <= '0;
							if (kpend_r) begin
								kpend_r   <= 1'b0;
								rx_nibble <= NIB_PREAMBLE;
								rx_dv     <= 1'b1;
							end else if (win_r == {SYM_T, SYM_R}) begin
								// Wait for I/I so the tail of T/R is not false carrier
								rx_state_r <= PDL_RX_FCAR;
								rx_dv      <= 1'b0;
								rx_er      <= 1'b0;
							end else if (win_r == {SYM_I, SYM_I}) begin
								rx_state_r <= PDL_RX_IDLE;
								rx_dv      <= 1'b1;
								rx_er      <= 1'b1;
								esd_evt_r  <= 1'b1;
							end else begin
								rx_nibble <= dec_hi[3:0];
								rx_dv     <= 1'b1;
								rx_er     <= ~dec_hi[4];
							end
						end else begin
							bit_cnt_r <= bit_cnt_r + 1'b1;
						end
					end
					default: begin
						rx_state_r <= PDL_RX_IDLE;
					end
				endcase
			end
		end
	end

	// Carrier sense for both speeds
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx10_act_r <= 1'b0;
			sq_d_r     <= 1'b0;
			crs        <= 1'b0;
		end else begin
			sq_d_r <= squelch_valid;
			if (speed_100 || soi_detect) begin
				rx10_act_r <= 1'b0;
			end else if (squelch_valid && !sq_d_r) begin
				rx10_act_r <= 1'b1;
			end
			crs <= speed_100 ? (rx_state_r == PDL_RX_RECV) : rx10_act_r;
		end
	end
endmodule

//--- pdl_core_asserts.sv
// Concurrent checks on the ports of the delimiter, link and negotiation block
`timescale 1ns/1ps
module pdl_core_asserts
	import pdl_pkg::*;
(
	input wire logic       core_clk,            // System clock
	input wire logic       rst,                 // Asynchronous reset
	input wire logic       transmit_enable,     // MAC transmit enable
	input wire logic [4:0] tx_code,             // Code group out
	input wire logic       start_of_idle_pulse, // 10 Mbps end pulse
	input wire logic       link_pulse_enable,   // Link pulses allowed
	input wire logic       tx_line_idle,        // Line forced idle
	input wire logic       collision,           // Collision to MAC
	input wire logic       squelch_valid,       // Squelch valid
	input wire logic [3:0] rx_nibble,           // Receive nibble
	input wire logic       rx_dv,               // Receive data valid
	input wire logic       false_carrier,       // False carrier pulse
	input wire logic       crs,                 // Carrier sense
	input wire logic       speed_100            // Applied speed
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (rst);
	property p_sof;
		$rose(transmit_enable) && speed_100 && !tx_line_idle |=> tx_code == SYM_J ##1 tx_code == SYM_K;
	endproperty
	a_sof: assert property (p_sof) else $error("start delimiter missing");
	property p_eof;
		$fell(transmit_enable) && speed_100 && !tx_line_idle
			|=> tx_code == SYM_T ##1 tx_code == SYM_R ##1 tx_code == SYM_I;
	endproperty
	a_eof: assert property (p_eof) else $error("end delimiter missing");
	property p_pre;
		$rose(rx_dv) |-> rx_nibble == NIB_PREAMBLE;
	endproperty
	a_pre: assert property (p_pre) else $error("start not shown as preamble");
	property p_fcar;
		false_carrier |-> !rx_dv ##1 !false_carrier;
	endproperty
	a_fcar: assert property (p_fcar) else $error("false carrier not a lone pulse");
	property p_crs;
		$rose(squelch_valid) && !speed_100 |-> ##[1:2] crs;
	endproperty
	a_crs: assert property (p_crs) else $error("carrier sense late");
	property p_soi;
		$fell(transmit_enable) && !speed_100 && !tx_line_idle |=> start_of_idle_pulse;
	endproperty
	a_soi: assert property (p_soi) else $error("start-of-idle pulse missing");
	property p_hold;
		!link_pulse_enable |-> tx_line_idle;
	endproperty
	a_hold: assert property (p_hold) else $error("pulses stopped with line live");
	property p_jab;
		speed_100 [*3] |-> !collision;
	endproperty
	a_jab: assert property (p_jab) else $error("jabber collision at 100 Mbps");
	property p_slow;
		!speed_100 [*2] |-> tx_code == SYM_I;
	endproperty
	a_slow: assert property (p_slow) else $error("code groups sent at 10 Mbps");
endmodule

bind pdl_core pdl_core_asserts i_pdl_core_asserts (.core_clk, .rst, .transmit_enable,
	.tx_code, .start_of_idle_pulse, .link_pulse_enable, .tx_line_idle, .collision,
	.squelch_valid, .rx_nibble, .rx_dv, .false_carrier, .crs, .speed_100);

//--- pdl_partner.sv
// Link partner model: serial code-group source and capability word strobe
`timescale 1ns/1ps
module pdl_partner
	import pdl_pkg::*;
(
	input  wire logic core_clk,           // System clock
	input  wire logic rst,                // Asynchronous reset
	input  wire logic flp_en,             // Partner sends FLP bursts
	output logic      rx_bit,             // Code bits, MSB first
	output logic      flp_seen,           // FLP bursts present
	output logic      partner_word_valid  // Word strobe every 16 cycles
);
	logic [4:0] sq[$];
	logic [4:0] sh_r;
	logic [4:0] cur;
	logic [2:0] bit_r;
	logic [3:0] wcnt_r;
	assign flp_seen = flp_en;
	// Active idle fills every gap, as a live 100 Mbps partner does
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sh_r <= SYM_I;
			bit_r <= 3'h0;
			wcnt_r <= 4'h0;
			rx_bit <= 1'b1;
			partner_word_valid <= 1'b0;
		end else begin
			cur = (bit_r != 3'h0) ? sh_r : (sq.size() > 0) ? sq.pop_front() : SYM_I;
			rx_bit <= cur[4];
			sh_r <= {cur[3:0], 1'b1};
			bit_r <= (bit_r == SYM_LAST_BIT) ? 3'h0 : bit_r + 3'h1;
			wcnt_r <= wcnt_r + 4'h1;
			partner_word_valid <= flp_en && (wcnt_r == 4'hF);
		end
	end
endmodule

//--- tb_top.sv
// Self-checking bench for the delimiter, link and negotiation block
`timescale 1ns/1ps
module tb_top;
	import pdl_pkg::*;
	logic core_clk, rst, reg_wr, reg_rd, transmit_enable, squelch_valid, descr_locked;
	logic soi_detect, nlp_link_ok, flp_seen, partner_word_valid, flp_en, rx_bit;
	logic start_of_idle_pulse, link_pulse_enable, tx_line_idle, collision, fc_seen;
	logic rx_dv, rx_er, false_carrier, crs, adv_send, link_pass, speed_100, full_duplex;
	logic col_seen;
	logic [AW-1:0] reg_addr;
	logic [DW-1:0] reg_wdata, reg_rdata, adv_word, partner_word, rnd;
	logic [3:0] tx_nibble, rx_nibble, nq[$], got[$];
	logic [4:0] tx_code, txq[$], sq[$];
	int miscompares, comparisons, cyc, dvc;
	pdl_core #(.MS_CYC(10), .JAB_CYC(50)) i_pdl_core (.core_clk, .rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .transmit_enable, .tx_nibble, .tx_code,
		.start_of_idle_pulse, .link_pulse_enable, .tx_line_idle, .collision, .rx_bit,
		.squelch_valid, .descr_locked, .soi_detect, .nlp_link_ok, .flp_seen,
		.partner_word_valid, .partner_word, .rx_nibble, .rx_dv, .rx_er, .false_carrier,
		.crs, .adv_send, .adv_word, .link_pass, .speed_100, .full_duplex);
	pdl_partner i_pdl_partner (.core_clk, .rst, .flp_en, .rx_bit, .flp_seen, .partner_word_valid);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [4:0] enc(input logic [3:0] n);
		logic [4:0] t[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
			5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
		return t[n];
	endfunction
	task automatic give_verdict();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask
	task automatic tx_frame(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			rnd = lfsr(rnd);
			transmit_enable <= 1'b1;
			tx_nibble <= rnd[3:0];
			if (i >= 2) nq.push_back(rnd[3:0]);
		end
		@(posedge core_clk);
		transmit_enable <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	// n is the symbol count on the wire less the two delimiter pairs' overlap
	task automatic tx_check(input int n);
		chk(16'(txq.size()), 16'(n == 0 ? 0 : n + 2));
		for (int i = 0; i < txq.size() && i < n + 2; i++)
			chk(16'(txq[i]), 16'(i == 0 ? SYM_J : i == 1 ? SYM_K : i == n ? SYM_T
				: i == n + 1 ? SYM_R : enc(nq[i - 2])));
		txq.delete();
		nq.delete();
	endtask
	task automatic rx_send();
		foreach (sq[i]) i_pdl_partner.sq.push_back(sq[i]);
		repeat (5 * sq.size() + 20) @(posedge core_clk);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (tx_code !== SYM_I) txq.push_back(tx_code);
		if (rx_dv === 1'b1) begin
			if (dvc % 5 == 0) got.push_back(rx_nibble);
			dvc++;
		end else dvc = 0;
		fc_seen |= (false_carrier === 1'b1);
		col_seen |= (collision === 1'b1);
		if (cyc >= 60000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		{rst, reg_wr, reg_rd, transmit_enable, squelch_valid, descr_locked} = 6'h20;
		{soi_detect, nlp_link_ok, flp_en, fc_seen, col_seen} = 5'h0;
		{reg_addr, reg_wdata, tx_nibble, partner_word} = '0;
		rnd = 16'h4F60;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(ADR_MAC_CTRL, 16'hFFFF, 16'h0000);
		rd(ADR_PHY_CTRL, 16'hFFFF, 16'h0001);
		rd(ADR_ADV, 16'hFFFF, ADV_RST);
		rd(3'h5, 16'hFFFF, 16'h0000);
		rd(ADR_STATUS, 16'h007F, 16'h0000);
		rnd = lfsr(rnd);
		wr(ADR_ADV, rnd);
		rd(ADR_ADV, 16'hFFFF, rnd);
		wr(ADR_ADV, ADV_RST);
		wr(ADR_MAC_CTRL, 16'h0006);
		chk({speed_100, full_duplex}, 16'h3);
		wr(ADR_MAC_CTRL, 16'h0002);
		squelch_valid <= 1'b1;
		wr(ADR_MAC_CTRL, 16'h0002);
		chk(link_pass, 16'h0);
		descr_locked <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(link_pass, 16'h1);
		txq.delete();
		tx_frame(9);
		tx_check(9);
		sq = {SYM_I, SYM_I, SYM_J, SYM_K};
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			nq.push_back(rnd[3:0]);
			sq.push_back(enc(rnd[3:0]));
		end
		sq = {sq, SYM_T, SYM_R, SYM_I, SYM_I};
		rx_send();
		for (int i = 0; i < 6; i++) chk(16'(got[i]), 16'(i < 2 ? NIB_PREAMBLE : nq[i - 2]));
		chk(rx_dv, 16'h0);
		nq.delete();
		got.delete();
		sq = {SYM_I, 5'h1E, SYM_I, SYM_I};
		rx_send();
		chk({fc_seen, 15'(got.size())}, 16'h0);
		sq = {SYM_I, 5'h15, SYM_J, SYM_K, enc(4'h3), SYM_T, SYM_R, SYM_I, SYM_I};
		rx_send();
		chk({fc_seen, 15'(got.size())}, 16'h8000);
		rd(ADR_STATUS, 16'h0030, 16'h0010);
		sq = {SYM_J, SYM_K, enc(4'h3), enc(4'h4), SYM_I, SYM_I, SYM_I};
		rx_send();
		rd(ADR_STATUS, 16'h0030, 16'h0020);
		wr(ADR_MAC_CTRL, 16'h0000);
		squelch_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
		squelch_valid <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(crs, 16'h1);
		soi_detect <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(crs, 16'h0);
		soi_detect <= 1'b0;
		tx_frame(8);
		tx_check(0);
		tx_frame(60);
		chk({col_seen, tx_line_idle}, 16'h2);
		rd(ADR_STATUS, 16'h0040, 16'h0040);
		wr(ADR_PHY_CTRL, 16'h0021);
		col_seen = 1'b0;
		tx_frame(60);
		chk(col_seen, 16'h0);
		tx_check(0);
		flp_en <= 1'b1;
		partner_word <= 16'h00C1;
		wr(ADR_PHY_CTRL, 16'h0001);
		wr(ADR_MAC_CTRL, 16'h0001);
		repeat (3) @(posedge core_clk);
		chk({link_pass, link_pulse_enable, tx_line_idle}, 16'h1);
		repeat (15000) @(posedge core_clk);
		rd(ADR_STATUS, 16'h000F, 16'h0007);
		rd(ADR_PARTNER, 16'hFFFF, 16'h00C1);
		chk({speed_100, full_duplex, adv_word[8:0]}, {5'h0, 2'h2, ADV_RST[8:0]});
		wr(ADR_PHY_CTRL, 16'h0009);
		repeat (3) @(posedge core_clk);
		chk({link_pass, link_pulse_enable}, 16'h0);
		{flp_en, squelch_valid, descr_locked, nlp_link_ok} <= 4'h1;
		repeat (15000) @(posedge core_clk);
		rd(ADR_STATUS, 16'h000F, 16'h0003);
		wr(ADR_PHY_CTRL, 16'h0006);
		chk({speed_100, full_duplex}, 16'h3);
		rd(ADR_STATUS, 16'h0001, 16'h0000);
		nlp_link_ok <= 1'b0;
		wr(ADR_PHY_CTRL, 16'h0016);
		repeat (3) @(posedge core_clk);
		chk({link_pass, link_pulse_enable, speed_100, full_duplex}, 16'hF);
		give_verdict();
	end
endmodule
